/* File: rtl/curtain_consts.svh */
// Timing constants for the light curtain interlock monitor
`ifndef CURTAIN_CONSTS_SVH
`define CURTAIN_CONSTS_SVH

`define CLK_FREQ_HZ        100000000
`define RESET_MIN_MS       150
`define RESET_MAX_MS       4000
`define FEEDBACK_WINDOW_MS 350
`define RESET_MIN_CYCLES   ((`CLK_FREQ_HZ / 1000) * `RESET_MIN_MS)
`define RESET_MAX_CYCLES   ((`CLK_FREQ_HZ / 1000) * `RESET_MAX_MS)
`define FEEDBACK_CYCLES    ((`CLK_FREQ_HZ / 1000) * `FEEDBACK_WINDOW_MS)
`define STUCK_CYCLES_MULT  2
`define MAX_UNITS          3
`define BEAM_CNT_W         8
`define TIMER_W            32

`endif

/* File: rtl/curtain_pkg.sv */
// Types of the light curtain interlock monitor
package curtain_pkg;

    typedef struct packed {
        logic internalErr;
        logic scanErr;
        logic feedbackErr;
        logic cascadeErr;
        logic restartErr;
        logic outputErr;
        logic supplyErr;
    } fault_type;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic       blocked;
        logic       syncBeam;
        logic [1:0] unit;
    } beam_type;

    typedef enum logic [1:0] {
        RUN_OFF,
        RUN_ON,
        RUN_LOCKOUT
    } run_state_type;

endpackage : curtain_pkg

/* File: rtl/light_curtain_interlock_monitor.sv */
// Receiver control: safety outputs, restart interlock, feedback monitor
`timescale 1ns/100ps
`include "curtain_consts.svh"
module light_curtain_interlock_monitor
    import curtain_pkg::*;
#(
    parameter logic [`TIMER_W-1:0] RESET_MIN = `RESET_MIN_CYCLES,
    parameter logic [`TIMER_W-1:0] RESET_MAX = `RESET_MAX_CYCLES,
    parameter logic [`TIMER_W-1:0] FB_WINDOW = `FEEDBACK_CYCLES
) (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      restartInterlockPin,
    input  wire logic      feedbackMonitorPin,
    input  wire logic      resetButtonPin,
    input  wire logic      feedbackPin,
    input  wire beam_type  beam,
    input  wire logic [1:0] unitCount,
    input  wire logic      cascadeLinkOk,
    input  wire logic      internalFault,
    input  wire logic      outputReadback,
    input  wire logic      supplyOk,
    output logic [1:0]     safetySwitchOutput,
    output fault_type      fault,
    output logic           lockout,
    output logic           restartInterlockArmed,
    output logic           contactorFeedbackMonitor,
    output logic           powerIndicator,
    output logic           synced
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] resSync;
    logic [1:0] monSync;
    logic [1:0] btnSync;
    logic [1:0] fbSync;
    logic [1:0] supSync;
    logic [1:0] rbSync;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resSync <= 2'h0;
            monSync <= 2'h0;
            btnSync <= 2'h0;
            fbSync  <= 2'h0;
            supSync <= 2'h0;
            rbSync  <= 2'h0;
        end else begin
            resSync <= {resSync[0], restartInterlockPin};
            monSync <= {monSync[0], feedbackMonitorPin};
            btnSync <= {btnSync[0], resetButtonPin};
            fbSync  <= {fbSync[0], feedbackPin};
            supSync <= {supSync[0], supplyOk};
            rbSync  <= {rbSync[0], outputReadback};
        end
    end

    // ------------------------------------------------------------
    // Static configuration captured after reset release
    // ------------------------------------------------------------
    logic       interlockEnabled;
    logic       feedbackEnabled;
    logic [1:0] configDelay;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            configDelay      <= 2'h0;
            interlockEnabled <= 1'b1;
            feedbackEnabled  <= 1'b0;
        end else if (configDelay != 2'h3) begin
            configDelay      <= configDelay + 2'h1;
            interlockEnabled <= resSync[1];
            feedbackEnabled  <= monSync[1];
        end
    end

    wire configReady = (configDelay == 2'h3);

    // ------------------------------------------------------------
    // Reset button qualification
    // ------------------------------------------------------------
    logic validReset;
    logic buttonStuck;

    reset_button_filter #(
        .MIN_CYCLES (RESET_MIN),
        .MAX_CYCLES (RESET_MAX)
    ) buttonFilter (
        .clk           (clk),
        .rst_n         (rst_n),
        .buttonPressed (btnSync[1]),
        .validReset    (validReset),
        .stuck         (buttonStuck)
    );

    // ------------------------------------------------------------
    // Scan evaluation
    // ------------------------------------------------------------
    logic                   scanActive;
    logic                   scanBlocked;
    logic                   fieldClear;
    logic                   scanDone;
    logic [`BEAM_CNT_W-1:0] beamIndex;
    logic                   scanError;

    // A sync beam from unit 0 opens a scan only when beamIndex is zero; beams from a unit below unitCount outside a scan are a scan error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scanActive  <= 1'b0;
            scanBlocked <= 1'b0;
            fieldClear  <= 1'b0;
            scanDone    <= 1'b0;
            beamIndex   <= '0;
            synced      <= 1'b0;
            scanError   <= 1'b0;
        end else begin
            scanDone  <= 1'b0;
            scanError <= 1'b0;
            if (beam.valid && beam.unit < 2'(`MAX_UNITS) && beam.unit < unitCount) begin
                if (beam.syncBeam && beam.unit == 2'h0 && beamIndex == '0) begin
                    scanActive  <= !beam.last;
                    scanBlocked <= beam.blocked;
                    beamIndex   <= beam.last ? '0 : 8'h1;
                    synced      <= 1'b1;
                    if (beam.last) begin
                        scanDone   <= 1'b1;
                        fieldClear <= !beam.blocked;
                    end
                end else if (scanActive && !beam.syncBeam) begin
                    beamIndex   <= beam.last ? '0 : beamIndex + 8'h1;
                    scanBlocked <= scanBlocked | beam.blocked;
                    if (beam.last) begin
                        scanActive <= 1'b0;
                        scanDone   <= 1'b1;
                        fieldClear <= !(scanBlocked | beam.blocked);
                    end
                end else begin
                    scanActive <= 1'b0;
                    beamIndex  <= '0;
                    synced     <= 1'b0;
                    scanError  <= 1'b1;
                end
            end
        end
    end

    wire beamInterrupt = beam.valid && beam.blocked;

    // ------------------------------------------------------------
    // Readback alignment
    // ------------------------------------------------------------
    logic [1:0] outHist;

    // Output delayed to match the readback synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outHist <= 2'h0;
        end else begin
            outHist <= {outHist[0], safetySwitchOutput[0]};
        end
    end

    // ------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------
    run_state_type state;
    logic          feedbackFail;
    logic          outputMismatch;

    assign outputMismatch = (rbSync[1] != outHist[1]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault <= '0;
        end else begin
            if (internalFault)           fault.internalErr <= 1'b1;
            if (scanError)               fault.scanErr     <= 1'b1;
            if (feedbackFail)            fault.feedbackErr <= 1'b1;
            if (!cascadeLinkOk && unitCount > 2'h1) fault.cascadeErr <= 1'b1;
            if (buttonStuck)             fault.restartErr  <= 1'b1;
            if (configReady && outputMismatch) fault.outputErr <= 1'b1;
            if (configReady && !supSync[1])    fault.supplyErr <= 1'b1;
        end
    end

    assign lockout = |fault;

    // ------------------------------------------------------------
    // Feedback window timer
    // ------------------------------------------------------------
    logic [`TIMER_W-1:0] fbTimer;
    logic                fbWaitOpen;
    logic                fbWaitClose;
    wire                 feedbackClosed = fbSync[1];
    logic                switchOn;
    logic                switchOff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fbTimer      <= '0;
            fbWaitOpen   <= 1'b0;
            fbWaitClose  <= 1'b0;
            feedbackFail <= 1'b0;
        end else begin
            feedbackFail <= 1'b0;
            if (!feedbackEnabled) begin
                fbWaitOpen  <= 1'b0;
                fbWaitClose <= 1'b0;
                fbTimer     <= '0;
            end else if (switchOn) begin
                fbWaitOpen  <= 1'b1;
                fbWaitClose <= 1'b0;
                fbTimer     <= '0;
            end else if (switchOff) begin
                fbWaitOpen  <= 1'b0;
                fbWaitClose <= 1'b1;
                fbTimer     <= '0;
            end else if (fbWaitOpen) begin
                if (!feedbackClosed) begin
                    fbWaitOpen <= 1'b0;
                end else if (fbTimer >= FB_WINDOW - 1) begin
                    fbWaitOpen   <= 1'b0;
                    feedbackFail <= 1'b1;
                end else begin
                    fbTimer <= fbTimer + 1'b1;
                end
            end else if (fbWaitClose) begin
                if (feedbackClosed) begin
                    fbWaitClose <= 1'b0;
                end else if (fbTimer >= FB_WINDOW - 1) begin
                    fbWaitClose  <= 1'b0;
                    feedbackFail <= 1'b1;
                end else begin
                    fbTimer <= fbTimer + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output state machine
    // ------------------------------------------------------------
    wire feedbackReady = !feedbackEnabled || (feedbackClosed && !fbWaitClose);
    wire startAllowed  = configReady && !lockout && fieldClear && !scanBlocked && feedbackReady;

    always_comb begin
        switchOn  = 1'b0;
        switchOff = 1'b0;
        case (state)
            RUN_OFF: begin
                if (interlockEnabled) begin
                    switchOn = startAllowed && validReset && !beamInterrupt;
                end else begin
                    switchOn = startAllowed && scanDone && !beamInterrupt;
                end
            end
            RUN_ON: begin
                switchOff = beamInterrupt || lockout || feedbackFail;
            end
            RUN_LOCKOUT: begin
                switchOff = 1'b0;
            end
            default: begin
                switchOff = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= RUN_OFF;
        end else begin
            case (state)
                RUN_OFF: begin
                    if (lockout) begin
                        state <= RUN_LOCKOUT;
                    end else if (switchOn) begin
                        state <= RUN_ON;
                    end
                end
                RUN_ON: begin
                    if (lockout || feedbackFail) begin
                        state <= RUN_LOCKOUT;
                    end else if (switchOff) begin
                        state <= RUN_OFF;
                    end
                end
                RUN_LOCKOUT: begin
                    state <= RUN_LOCKOUT;
                end
                default: begin
                    state <= RUN_LOCKOUT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            safetySwitchOutput <= 2'h0;
        end else begin
            safetySwitchOutput <= (state == RUN_ON && !switchOff) ? 2'h3 : 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            restartInterlockArmed    <= 1'b0;
            contactorFeedbackMonitor <= 1'b0;
            powerIndicator           <= 1'b0;
        end else begin
            restartInterlockArmed    <= interlockEnabled && state == RUN_OFF && fieldClear;
            contactorFeedbackMonitor <= feedbackEnabled;
            powerIndicator           <= 1'b1;
        end
    end

endmodule : light_curtain_interlock_monitor

/* File: rtl/reset_button_filter.sv */
// Press duration qualifier for the reset button
`timescale 1ns/100ps
`include "curtain_consts.svh"
module reset_button_filter
    import curtain_pkg::*;
#(
    parameter logic [`TIMER_W-1:0] MIN_CYCLES = `RESET_MIN_CYCLES,
    parameter logic [`TIMER_W-1:0] MAX_CYCLES = `RESET_MAX_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic buttonPressed,
    output logic      validReset,
    output logic      stuck
);

    logic [`TIMER_W-1:0] pressTime;
    logic                pressedLast;

    // ------------------------------------------------------------
    // Press timer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pressTime   <= '0;
            pressedLast <= 1'b0;
        end else begin
            pressedLast <= buttonPressed;
            if (!buttonPressed) begin
                pressTime <= '0;
            end else if (pressTime != '1) begin
                pressTime <= pressTime + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Release qualification
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            validReset <= 1'b0;
        end else begin
            validReset <= pressedLast && !buttonPressed &&
                          pressTime >= MIN_CYCLES && pressTime <= MAX_CYCLES;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stuck <= 1'b0;
        end else begin
            stuck <= buttonPressed && (pressTime >= (MAX_CYCLES << 1));
        end
    end

endmodule : reset_button_filter

/* File: testbench/contactor_model.sv */
// Downstream contactor pair with feedback contact
`timescale 1ns/100ps
module contactor_model #(
    parameter int DELAY = 5
) (
    input  wire logic       clk,
    input  wire logic [1:0] energise,
    input  wire logic       weld,
    input  wire logic       holdOpen,
    input  wire logic       badReadback,
    output logic            feedbackPin,
    output logic            outputReadback
);
    // ----------------------------------------
    // Armature
    // ----------------------------------------
    int   settle = 0;
    logic pulledIn = 1'b0;

    always_ff @(posedge clk) begin
        if ((energise == 2'h3) == pulledIn) begin
            settle <= 0;
        end else if (settle < DELAY - 1) begin
            settle <= settle + 1;
        end else begin
            pulledIn <= ~pulledIn;
            settle <= 0;
        end
    end
    // Closed contact, welded or broken on command
    assign feedbackPin = !holdOpen && (weld || !pulledIn);
    assign outputReadback = energise[0] ^ badReadback;
endmodule : contactor_model

/* File: testbench/light_curtain_interlock_monitor_chk.sv */
// Port checks for the light curtain interlock monitor
`timescale 1ns/100ps
`include "curtain_consts.svh"
module light_curtain_interlock_monitor_chk
    import curtain_pkg::*;
#(
    parameter logic [`TIMER_W-1:0] RESET_MIN = `RESET_MIN_CYCLES,
    parameter logic [`TIMER_W-1:0] RESET_MAX = `RESET_MAX_CYCLES,
    parameter logic [`TIMER_W-1:0] FB_WINDOW = `FEEDBACK_CYCLES
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       resetButtonPin,
    input wire logic       feedbackPin,
    input wire beam_type   beam,
    input wire logic [1:0] unitCount,
    input wire logic [1:0] safetySwitchOutput,
    input wire fault_type  fault,
    input wire logic       lockout,
    input wire logic       restartInterlockArmed,
    input wire logic       contactorFeedbackMonitor
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic [`TIMER_W-1:0] pressLen;
    logic [7:0]          sinceRel;
    logic [`TIMER_W-1:0] openLate;
    logic [`TIMER_W-1:0] closeLate;

    always_ff @(posedge clk) begin
        pressLen <= (rst_n && resetButtonPin) ? pressLen + 1 : '0;
    end
    always_ff @(posedge clk) begin
        sinceRel <= (!rst_n || resetButtonPin) ? 8'h0 : sinceRel + {7'h0, sinceRel != 8'hff};
    end
    always_ff @(posedge clk) begin
        openLate <= (rst_n && safetySwitchOutput == 2'h3 && feedbackPin && contactorFeedbackMonitor)
            ? openLate + 1 : '0;
    end
    always_ff @(posedge clk) begin
        closeLate <= (rst_n && safetySwitchOutput == 2'h0 && !feedbackPin && contactorFeedbackMonitor
            && !lockout) ? closeLate + 1 : '0;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_lockout_sum: assert property (lockout == (|fault))
        else $error("lockout differs from fault OR");
    chk_lockout_off: assert property (lockout |=> ##1 (safetySwitchOutput == 2'h0))
        else $error("outputs on during lockout");
    chk_fault_sticky: assert property ((~fault & $past(fault)) == 7'h0)
        else $error("latched fault cleared");
    chk_blocked_off: assert property (beam.valid && beam.blocked && beam.unit < unitCount
        |-> ##[1:3] (safetySwitchOutput == 2'h0))
        else $error("outputs on after blocked beam");
    chk_open_late: assert property (openLate <= FB_WINDOW + 32'h6)
        else $error("feedback open timeout missed");
    chk_close_late: assert property (closeLate <= FB_WINDOW + 32'h6)
        else $error("feedback close timeout missed");
    chk_release_on: assert property ($rose(safetySwitchOutput[0]) && $past(restartInterlockArmed)
        |-> sinceRel >= 8'h2 && sinceRel <= 8'h9)
        else $error("switch-on without button release");
    chk_bad_press: assert property ($fell(resetButtonPin) && restartInterlockArmed
        && (pressLen < RESET_MIN - 32'h2 || pressLen > RESET_MAX + 32'h2)
        |-> (safetySwitchOutput == 2'h0)[*8])
        else $error("out of window press accepted");
    chk_fb_ignored: assert property (!contactorFeedbackMonitor && !$past(contactorFeedbackMonitor)
        |-> !$rose(fault.feedbackErr))
        else $error("feedback error while monitor off");
endmodule : light_curtain_interlock_monitor_chk

/* File: testbench/light_curtain_interlock_monitor_tb.sv */
// Bench for the light curtain interlock monitor
`timescale 1ns/100ps
module light_curtain_interlock_monitor_tb
    import curtain_pkg::*;
;
    localparam int MIN_P = 32'h5;
    localparam int MAX_P = 32'h28;
    localparam int FB_W  = 32'h14;

    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       restartInterlockPin = 1'b0;
    logic       feedbackMonitorPin = 1'b0;
    logic       resetButtonPin = 1'b0;
    logic       feedbackPin;
    beam_type   beam = '0;
    logic [1:0] unitCount = 2'h1;
    logic       cascadeLinkOk = 1'b1;
    logic       internalFault = 1'b0;
    logic       outputReadback;
    logic       supplyOk = 1'b1;
    logic [1:0] safetySwitchOutput;
    fault_type  fault;
    logic       lockout;
    logic       restartInterlockArmed;
    logic       contactorFeedbackMonitor;
    logic       powerIndicator;
    logic       synced;
    logic       weld = 1'b0;
    logic       holdOpen = 1'b0;
    logic       badReadback = 1'b0;
    int         failures = 0;
    int         totalChecks = 0;

    light_curtain_interlock_monitor #(.RESET_MIN(MIN_P), .RESET_MAX(MAX_P), .FB_WINDOW(FB_W)) dut (
        .clk(clk), .rst_n(rst_n), .restartInterlockPin(restartInterlockPin),
        .feedbackMonitorPin(feedbackMonitorPin), .resetButtonPin(resetButtonPin), .feedbackPin(feedbackPin),
        .beam(beam), .unitCount(unitCount), .cascadeLinkOk(cascadeLinkOk), .internalFault(internalFault),
        .outputReadback(outputReadback), .supplyOk(supplyOk), .safetySwitchOutput(safetySwitchOutput),
        .fault(fault), .lockout(lockout), .restartInterlockArmed(restartInterlockArmed),
        .contactorFeedbackMonitor(contactorFeedbackMonitor), .powerIndicator(powerIndicator), .synced(synced));

    contactor_model load (
        .clk(clk), .energise(safetySwitchOutput), .weld(weld), .holdOpen(holdOpen),
        .badReadback(badReadback), .feedbackPin(feedbackPin), .outputReadback(outputReadback));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic expOut(input logic [1:0] e);
        check(8'(safetySwitchOutput), 8'(e));
    endtask : expOut

    task automatic doReset(input logic ilk, input logic fbm, input logic [1:0] units);
        @(posedge clk);
        rst_n <= 1'b0;
        restartInterlockPin <= ilk;
        feedbackMonitorPin <= fbm;
        unitCount <= units;
        {internalFault, weld, holdOpen, badReadback, resetButtonPin} <= 5'h0;
        {cascadeLinkOk, supplyOk} <= 2'h3;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : doReset

    task automatic sendBeam(input logic s, input logic l, input logic b);
        @(posedge clk);
        beam <= {1'b1, l, b, s, 2'h0};
    endtask : sendBeam

    task automatic scan(input logic b);
        sendBeam(1'b1, 1'b0, 1'b0);
        sendBeam(1'b0, 1'b0, b);
        sendBeam(1'b0, 1'b0, 1'b0);
        sendBeam(1'b0, 1'b1, 1'b0);
        @(posedge clk);
        beam <= '0;
        repeat (4) @(posedge clk);
    endtask : scan

    task automatic press(input int n);
        @(posedge clk);
        resetButtonPin <= 1'b1;
        repeat (n) @(posedge clk);
        resetButtonPin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : press

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_auto;
        weld <= 1'b1;
        scan(1'b0);
        expOut(2'h3);
        check(8'(synced), 8'h1);
        check(8'(contactorFeedbackMonitor), 8'h0);
        scan(1'b1);
        expOut(2'h0);
        scan(1'b0);
        repeat (FB_W + 8) @(posedge clk);
        expOut(2'h3);
        check(8'(fault), 8'h0);
        @(posedge clk);
        beam <= {1'b1, 3'h0, 2'h2};
        @(posedge clk);
        beam <= '0;
        repeat (4) @(posedge clk);
        check(8'(fault), 8'h0);
        expOut(2'h3);
    endtask : test_auto

    task automatic test_interlock;
        doReset(1'b1, 1'b0, 2'h1);
        scan(1'b0);
        expOut(2'h0);
        check(8'(restartInterlockArmed), 8'h1);
        press(MIN_P - 3);
        expOut(2'h0);
        press(MAX_P + 20);
        expOut(2'h0);
        check(8'(lockout), 8'h0);
        press(MIN_P + 1);
        expOut(2'h3);
        scan(1'b1);
        scan(1'b0);
        expOut(2'h0);
        press(MAX_P - 1);
        expOut(2'h3);
    endtask : test_interlock

    task automatic test_feedback;
        doReset(1'b0, 1'b1, 2'h1);
        check(8'(contactorFeedbackMonitor), 8'h1);
        holdOpen <= 1'b1;
        scan(1'b0);
        expOut(2'h0);
        holdOpen <= 1'b0;
        repeat (4) @(posedge clk);
        scan(1'b0);
        expOut(2'h3);
        scan(1'b1);
        repeat (FB_W + 8) @(posedge clk);
        check(8'(lockout), 8'h0);
        weld <= 1'b1;
        scan(1'b0);
        repeat (FB_W + 8) @(posedge clk);
        check(8'(fault), 8'h10);
        expOut(2'h0);
        scan(1'b0);
        expOut(2'h0);
        doReset(1'b0, 1'b1, 2'h1);
        scan(1'b0);
        expOut(2'h3);
        holdOpen <= 1'b1;
        scan(1'b1);
        repeat (FB_W + 8) @(posedge clk);
        check(8'(fault), 8'h10);
    endtask : test_feedback

    task automatic test_faults;
        for (int p = 0; p < 7; p++) begin
            if (p != 4) begin
                doReset(1'b1, 1'b0, (p == 3) ? 2'h2 : 2'h1);
                case (p)
                    6: internalFault <= 1'b1;
                    5: beam <= {1'b1, 5'h0};
                    3: cascadeLinkOk <= 1'b0;
                    2: resetButtonPin <= 1'b1;
                    1: badReadback <= 1'b1;
                    default: supplyOk <= 1'b0;
                endcase
                @(posedge clk);
                internalFault <= 1'b0;
                beam <= '0;
                repeat (2 * MAX_P + 20) @(posedge clk);
                check(8'(fault), 8'h1 << p);
                expOut(2'h0);
            end
        end
        doReset(1'b0, 1'b0, 2'h1);
        check(8'(lockout), 8'h0);
        check(8'(powerIndicator), 8'h1);
    endtask : test_faults

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic stop_test;
        $display("Checks: %0d, failures: %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test;
    end

    initial begin
        doReset(1'b0, 1'b0, 2'h1);
        test_auto;
        test_interlock;
        test_feedback;
        test_faults;
        stop_test;
    end
endmodule : light_curtain_interlock_monitor_tb

bind light_curtain_interlock_monitor light_curtain_interlock_monitor_chk #(
    .RESET_MIN(RESET_MIN), .RESET_MAX(RESET_MAX), .FB_WINDOW(FB_WINDOW)) chk (
    .clk(clk), .rst_n(rst_n), .resetButtonPin(resetButtonPin), .feedbackPin(feedbackPin), .beam(beam),
    .unitCount(unitCount), .safetySwitchOutput(safetySwitchOutput), .fault(fault), .lockout(lockout),
    .restartInterlockArmed(restartInterlockArmed), .contactorFeedbackMonitor(contactorFeedbackMonitor));
